// [common/swgc_cfg.svh]
// Register offsets, field positions, reset values and timing constants for the
// switch global control bits. Included by the package users and the design.
`ifndef SWGC_CFG_SVH
`define SWGC_CFG_SVH

`define SWGC_ADDR_W          8
`define SWGC_OFF_CTRL_ONE    8'h03
`define SWGC_OFF_CTRL_TWO    8'h04

// Global control one fields.
`define SWGC_B_TX_FC_DIS     5
`define SWGC_B_RX_FC_DIS     4
`define SWGC_B_LEN_CHECK     3
`define SWGC_B_AGE_EN        2
`define SWGC_B_FAST_AGE      1
`define SWGC_B_AGGR_BACKOFF  0
`define SWGC_ONE_MASK        8'h3F
`define SWGC_ONE_RST_FIXED   8'h04

// Global control two fields.
`define SWGC_B_VLAN_DISCARD  7
`define SWGC_B_MC_STORM_EXCL 6
`define SWGC_B_BP_MODE       5
`define SWGC_B_FAIR_MODE     4
`define SWGC_B_NO_COLL_DROP  3
`define SWGC_TWO_MASK        8'hF8
`define SWGC_TWO_RST_FIXED   8'hF0

// Frame and aging figures.
`define SWGC_LEN_TYPE_LIMIT  16'h05DC
`define SWGC_COLL_LIMIT      5'h10
`define SWGC_FAST_AGE_US     800
`define SWGC_CLK_MHZ         100
`define SWGC_FAST_AGE_CYC    (`SWGC_FAST_AGE_US * `SWGC_CLK_MHZ)

`endif

// [common/swgc_pkg.sv]
// Types shared by the switch global control bits design.
// Assumes the constants header is on the include path.
package swgc_pkg;
    typedef enum logic [1:0] {
        SWGC_RST_HOLD  = 2'b00,
        SWGC_RST_LOAD  = 2'b01,
        SWGC_RST_RUN   = 2'b10
    } swgc_phase_t;
endpackage

// [dv/swgc_global_ctrl_assertions.sv]
// Checker for the switch global control bits, bound to the top module.
// Assumes regRdata shows the addressed register in the same cycle.
`timescale 1ns/100ps
module swgc_global_ctrl_assertions (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  regAddr,
    input wire logic        regWrite,
    input wire logic [7:0]  regRdata,
    input wire logic        anRxPause,
    input wire logic        anTxPause,
    input wire logic [15:0] frameLenType,
    input wire logic [15:0] framePayloadLen,
    input wire logic [4:0]  collisionCount,
    input wire logic [47:0] frameDestAddr,
    input wire logic        frameKnownUnicast,
    input wire logic        congestShared,
    input wire logic        rxPauseEnable,
    input wire logic        txPauseEnable,
    input wire logic        lengthDrop,
    input wire logic        agingEnable,
    input wire logic        vlanCrossAllowed,
    input wire logic        stormMeter,
    input wire logic        dropNonPausedSource,
    input wire logic        pauseFlowSource,
    input wire logic        collisionDrop
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire        one = regAddr == 8'h03;
    wire        two = regAddr == 8'h04;
    logic [1:0] upCnt;
    // The strap load lands on the second edge, so holding is only judged later.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) upCnt <= 2'h0;
        else if (upCnt != 2'h3) upCnt <= upCnt + 2'h1;
    end
    a_rx_pause_gate: assert property (one |-> rxPauseEnable == (anRxPause && !regRdata[4]))
        else $error("rx pause gate wrong");
    a_tx_pause_gate: assert property (one |-> txPauseEnable == (anTxPause && !regRdata[5]))
        else $error("tx pause gate wrong");
    a_length_drop: assert property (one |-> lengthDrop == (regRdata[3]
        && frameLenType < 16'h05DC && frameLenType != framePayloadLen)) else $error("length drop");
    a_aging_enable: assert property (one |-> agingEnable == regRdata[2])
        else $error("aging enable wrong");
    a_vlan_cross: assert property (two |-> vlanCrossAllowed == (!regRdata[7] && frameKnownUnicast))
        else $error("vlan crossing wrong");
    a_storm_scope: assert property (two |-> stormMeter == (&frameDestAddr
        || (!regRdata[6] && frameDestAddr[40]))) else $error("storm scope wrong");
    a_fair_choice: assert property (congestShared |-> dropNonPausedSource != pauseFlowSource)
        else $error("fair choice wrong");
    a_coll_drop: assert property (two && collisionCount >= 5'h10 |-> collisionDrop == !regRdata[3])
        else $error("collision drop wrong");
    a_regs_hold: assert property (upCnt == 2'h3 && !$past(regWrite) && $stable(regAddr)
        |-> $stable(regRdata)) else $error("register changed unwritten");
endmodule
bind swgc_global_ctrl swgc_global_ctrl_assertions i_swgc_global_ctrl_assertions (.*);

// [dv/swgc_global_ctrl_test.sv]
// Self-checking bench for the switch global control bits.
// Assumes the constants header is on the include path.
`timescale 1ns/100ps
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t got %0h want %0h", $time, a, b); end end
module swgc_global_ctrl_test;
    logic clk = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, frameKnownUnicast = 1'b1;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
    logic flow_ctrl_strap_pin = 1'b0, backoff_strap_pin = 1'b0, collision_drop_strap_pin = 1'b0;
    logic anRxPause = 1'b1, anTxPause = 1'b1, congestShared = 1'b1;
    logic [15:0] frameLenType = 16'h05DB, framePayloadLen = 16'h0010;
    logic [4:0] collisionCount = 5'h10;
    logic [47:0] frameDestAddr = 48'h0100_0000_0000;
    logic [31:0] agePeriodFast;
    logic rxPauseEnable, txPauseEnable, lengthDrop, agingEnable, fastAgeSelect, aggressiveBackoff;
    logic vlanCrossAllowed, stormMeter, carrierBackPressure, dropNonPausedSource;
    logic pauseFlowSource, collisionDrop;
    int fails = 0, cmpCount = 0;
    swgc_global_ctrl #(.FAST_AGE_CYCLES(8)) i_swgc_global_ctrl (.*);
    always #5 clk = ~clk;
    task close_out;
        if (fails == 0 && cmpCount > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a; regWdata = d; regWrite = 1'b1;
        @(posedge clk) #1 regWrite = 1'b0;
        @(posedge clk) #1;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        regAddr = a;
        #1 `CHK(regRdata, e);
    endtask
    task t_reset(input logic [2:0] s);
        {flow_ctrl_strap_pin, collision_drop_strap_pin, backoff_strap_pin} = s;
        sys_rst = 1'b1;
        repeat (12) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (3) @(posedge clk);
        #1 {flow_ctrl_strap_pin, collision_drop_strap_pin, backoff_strap_pin} = ~s;
        @(posedge clk) #1;
        rd(8'h03, {2'b00, s[2], s[2], 3'b010, s[0]});
        rd(8'h04, {4'hF, s[1], 3'b000});
    endtask
    task t_regs;
        wr(8'h03, 8'hEA);
        wr(8'h04, 8'h0F);
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00);
        rd(8'h04, 8'h08);
        rd(8'h03, 8'h2A);
        `CHK({rxPauseEnable, txPauseEnable}, 2'b10);
    endtask
    task t_steer;
        `CHK({lengthDrop, agingEnable, fastAgeSelect, aggressiveBackoff}, 4'hA);
        `CHK(agePeriodFast, 32'h8);
        frameLenType = 16'h05DC;
        #1 `CHK(lengthDrop, 1'b0);
        `CHK({vlanCrossAllowed, stormMeter, carrierBackPressure}, 3'h6);
        `CHK({dropNonPausedSource, pauseFlowSource, collisionDrop}, 3'h2);
        wr(8'h04, 8'hF0);
        `CHK({vlanCrossAllowed, stormMeter, carrierBackPressure}, 3'h1);
        `CHK({dropNonPausedSource, pauseFlowSource, collisionDrop}, 3'h5);
        frameDestAddr = 48'hFFFF_FFFF_FFFF;
        collisionCount = 5'h0F;
        #1 `CHK({stormMeter, collisionDrop}, 2'h2);
    endtask
    initial begin
        #200000;
        fails++;
        close_out;
    end
    initial begin
        t_reset(3'b000);
        t_reset(3'b111);
        t_regs;
        t_steer;
        close_out;
    end
endmodule

// [logic/swgc_global_ctrl.sv]
// Switch global control bits: two 8-bit registers on the device register port,
// strap-loaded defaults, and decoded steering levels for MAC, forwarding and aging.
// Assumes a simple synchronous register port: address, write strobe, write data,
// read data valid in the same cycle. Strap pins are sampled after reset release.
`timescale 1ns/100ps
`include "swgc_cfg.svh"
// Overview of operation
// RULE1 - Rx pause off when disable bit set
// RULE2 - One strap loads both flow-control defaults
// RULE3 - Drop short length field mismatches
// RULE4 - Age entries only when enabled, default on
// RULE5 - Fast age selects 800 us period
// RULE6 - Aggressive backoff, strap default
// RULE7 - VLAN discard blocks unicast crossing
// RULE8 - Storm exclusion meters broadcast only
// RULE9 - Back pressure mode selects carrier sense
// RULE10 - Fair mode may drop non-paused source
// RULE11 - Unfair mode pauses flow-controlled source
// RULE12 - Drop after sixteen collisions unless disabled
// RULE13 - Tx pause off when disable bit set
// RULE14 - Straps sampled once at reset
module swgc_global_ctrl #(
    parameter int FAST_AGE_CYCLES = `SWGC_FAST_AGE_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic [`SWGC_ADDR_W-1:0] regAddr,
    input  wire logic                    regWrite,
    input  wire logic [7:0]              regWdata,
    output logic      [7:0]              regRdata,
    input  wire logic                    flow_ctrl_strap_pin,
    input  wire logic                    backoff_strap_pin,
    input  wire logic                    collision_drop_strap_pin,
    input  wire logic                    anRxPause,
    input  wire logic                    anTxPause,
    input  wire logic [15:0]             frameLenType,
    input  wire logic [15:0]             framePayloadLen,
    input  wire logic [4:0]              collisionCount,
    input  wire logic [47:0]             frameDestAddr,
    input  wire logic                    frameKnownUnicast,
    input  wire logic                    congestShared,
    output logic                         rxPauseEnable,
    output logic                         txPauseEnable,
    output logic                         lengthDrop,
    output logic                         agingEnable,
    output logic [31:0]                  agePeriodFast,
    output logic                         fastAgeSelect,
    output logic                         aggressiveBackoff,
    output logic                         vlanCrossAllowed,
    output logic                         stormMeter,
    output logic                         carrierBackPressure,
    output logic                         dropNonPausedSource,
    output logic                         pauseFlowSource,
    output logic                         collisionDrop
);
    initial begin
        if (FAST_AGE_CYCLES < 1) $error("swgc_global_ctrl: FAST_AGE_CYCLES must be positive");
    end

    // Register images. The masks keep the reserved positions at zero on every
    // path, so a read never shows a bit that the logic below does not honour.
    logic [7:0] ctrlOne;
    logic [7:0] ctrlTwo;
    logic [7:0] next_ctrlOne;
    logic [7:0] next_ctrlTwo;

    // Strap capture results.
    logic [2:0] strapValue;
    logic       strapValid;

    // Straps ordered: flow control, backoff, collision drop.
    swgc_strap_latch #(
        .WIDTH (3)
    ) u_strap (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .strapPins  ({flow_ctrl_strap_pin, backoff_strap_pin, collision_drop_strap_pin}),
        .strapValue (strapValue),
        .strapValid (strapValid)
    );

    // Register port decode. Both registers share one comparison so that a
    // change of the address width touches a single place.
    function automatic logic hitOffset(input logic [`SWGC_ADDR_W-1:0] addr,
                                       input logic [`SWGC_ADDR_W-1:0] off);
        hitOffset = (addr == off);
    endfunction

    wire hitOne = hitOffset(regAddr, `SWGC_OFF_CTRL_ONE);
    wire hitTwo = hitOffset(regAddr, `SWGC_OFF_CTRL_TWO);

    // A write strobe only counts while its address selects an implemented
    // register; strobes to any other offset fall through untouched.
    wire writeOne = regWrite & hitOne;
    wire writeTwo = regWrite & hitTwo;

    // Write data with the reserved positions cleared.
    wire [7:0] maskedOne = regWdata & `SWGC_ONE_MASK;
    wire [7:0] maskedTwo = regWdata & `SWGC_TWO_MASK;

    // RULE2 shared strap default
    wire [7:0] strapOne = `SWGC_ONE_RST_FIXED
                        | ({7'h00, strapValue[2]} << `SWGC_B_TX_FC_DIS)
                        | ({7'h00, strapValue[2]} << `SWGC_B_RX_FC_DIS)
                        | ({7'h00, strapValue[1]} << `SWGC_B_AGGR_BACKOFF);
    wire [7:0] strapTwo = `SWGC_TWO_RST_FIXED
                        | ({7'h00, strapValue[0]} << `SWGC_B_NO_COLL_DROP);

    // RULE14 load only once
    // The strap load wins over a write in the same cycle. Software cannot
    // reach the port that early in practice, and letting the load win keeps
    // the strapped defaults in force after every reset. The load pulse comes
    // exactly once per reset, so later pin changes never reach the registers.
    assign next_ctrlOne = strapValid ? strapOne
                        : (writeOne ? maskedOne : ctrlOne);
    assign next_ctrlTwo = strapValid ? strapTwo
                        : (writeTwo ? maskedTwo : ctrlTwo);

    // RULE4 aging default set
    // The reset images are constants; the strap-dependent bits arrive one
    // edge after the pins have been captured, together with the fixed ones.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlOne <= `SWGC_ONE_RST_FIXED;
        end else begin
            ctrlOne <= next_ctrlOne;
        end
    end

    // Global control two storage, same scheme as the first register.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlTwo <= `SWGC_TWO_RST_FIXED;
        end else begin
            ctrlTwo <= next_ctrlTwo;
        end
    end

    // Unmapped addresses read as zero so software can probe safely.
    // The read path is combinational: the value follows the address in the
    // same cycle and shows a write from the edge on which it was taken.
    assign regRdata = hitOne ? ctrlOne : (hitTwo ? ctrlTwo : 8'h00);

    // Field decode of global control one.
    wire txFcOff     = ctrlOne[`SWGC_B_TX_FC_DIS];
    wire rxFcOff     = ctrlOne[`SWGC_B_RX_FC_DIS];
    wire lenCheckOn  = ctrlOne[`SWGC_B_LEN_CHECK];
    wire ageOn       = ctrlOne[`SWGC_B_AGE_EN];
    wire fastAgeOn   = ctrlOne[`SWGC_B_FAST_AGE];
    wire aggrOn      = ctrlOne[`SWGC_B_AGGR_BACKOFF];

    // Field decode of global control two.
    wire vlanDiscard = ctrlTwo[`SWGC_B_VLAN_DISCARD];
    wire mcExcluded  = ctrlTwo[`SWGC_B_MC_STORM_EXCL];
    wire carrierMode = ctrlTwo[`SWGC_B_BP_MODE];
    wire fairMode    = ctrlTwo[`SWGC_B_FAIR_MODE];
    wire noCollDrop  = ctrlTwo[`SWGC_B_NO_COLL_DROP];

    // RULE1 receive pause gate
    // Negotiation decides whether the partner offered pause at all. The
    // disable bit can only take receive pause away; it never grants pause
    // to a partner that did not offer it.
    assign rxPauseEnable = anRxPause & ~rxFcOff;

    // RULE13 transmit pause gate
    // Same shape as the receive gate. The two bits share one strap default
    // but are written independently, so each direction can be tuned alone.
    assign txPauseEnable = anTxPause & ~txFcOff;

    // RULE3 length mismatch drop
    // Values at or above the limit are type codes, not lengths, and are
    // never compared. Only a short length field that disagrees with the
    // measured payload asks the receive path to drop the frame.
    wire shortLenField = frameLenType < `SWGC_LEN_TYPE_LIMIT;
    wire lenMismatch   = frameLenType != framePayloadLen;
    assign lengthDrop  = lenCheckOn & shortLenField & lenMismatch;

    // RULE4 aging gate
    // The aging engine stops while this level is low; entries already in
    // the table stay until aging is enabled again or they are rewritten.
    assign agingEnable = ageOn;

    // RULE5 fast age period
    // The period is handed over as a cycle count so that the aging engine
    // needs no knowledge of the clock rate. The count is fixed at build time;
    // only the choice between fast and normal aging is under software control.
    assign fastAgeSelect = fastAgeOn;
    assign agePeriodFast = 32'(FAST_AGE_CYCLES);

    // RULE6 aggressive backoff
    // Only half-duplex ports look at this level. It trades standard
    // back-off fairness for throughput on a busy shared segment.
    assign aggressiveBackoff = aggrOn;

    // RULE7 VLAN crossing
    // With discard set nothing crosses a port-VLAN boundary. With it clear,
    // known unicast may cross; unknown, multicast and broadcast still may not.
    assign vlanCrossAllowed = ~vlanDiscard & frameKnownUnicast;

    // RULE8 storm metering scope
    // The all-ones address is always metered. The group bit of the address
    // adds multicast frames to the metered set once exclusion is cleared.
    wire isBroadcast  = &frameDestAddr;
    wire isGroupFrame = frameDestAddr[40];
    assign stormMeter = isBroadcast | (~mcExcluded & isGroupFrame);

    // RULE9 back pressure style
    // High selects carrier-sense back pressure, low the collision style.
    assign carrierBackPressure = carrierMode;

    // RULE10 fair mode drop
    // Fair mode protects the flow-controlled port from being paused for a
    // long time by sacrificing frames of the port that cannot be paused.
    assign dropNonPausedSource = congestShared & fairMode;

    // RULE11 unfair mode pause
    // Without fair mode nothing is dropped; the flow-controlled source is
    // paused instead, which may starve it while the other port keeps sending.
    // Exactly one of the two actions is asked for under shared congestion.
    assign pauseFlowSource = congestShared & ~fairMode;

    // RULE12 excessive collision drop
    // The count input is wide enough to show the limit itself; any count at
    // or above it marks the frame as excessive.
    wire excessCollisions = collisionCount >= `SWGC_COLL_LIMIT;
    assign collisionDrop  = ~noCollDrop & excessCollisions;
endmodule

// [logic/swgc_strap_latch.sv]
// Strap capture: samples the strap pins once after reset release.
// Assumes the pins are synchronous to clk and stable around reset.
`timescale 1ns/100ps
`include "swgc_cfg.svh"
module swgc_strap_latch #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] strapPins,
    output logic      [WIDTH-1:0] strapValue,
    output logic                  strapValid
);
    initial begin
        if (WIDTH < 1) $error("swgc_strap_latch: WIDTH must be at least 1");
    end

    swgc_pkg::swgc_phase_t phase;
    swgc_pkg::swgc_phase_t next_phase;
    wire                   takeNow = (phase == swgc_pkg::SWGC_RST_HOLD);

    always_comb begin
        unique case (phase)
            swgc_pkg::SWGC_RST_HOLD: next_phase = swgc_pkg::SWGC_RST_LOAD;
            swgc_pkg::SWGC_RST_LOAD: next_phase = swgc_pkg::SWGC_RST_RUN;
            swgc_pkg::SWGC_RST_RUN:  next_phase = swgc_pkg::SWGC_RST_RUN;
            default:                 next_phase = swgc_pkg::SWGC_RST_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase <= swgc_pkg::SWGC_RST_HOLD;
        end else begin
            phase <= next_phase;
        end
    end

    // RULE14 sample once
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strapValue <= '0;
        end else if (takeNow) begin
            strapValue <= strapPins;
        end
    end

    assign strapValid = (phase == swgc_pkg::SWGC_RST_LOAD);
endmodule
